// ===== verilog/vdma_pkg.sv
// package for the video write dma control block: offsets, reset values,
// field positions, grab states and the line config carrier struct.
// assumes a 32-bit apb register bus and a single 100 MHz clock.
package vdma_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_DISP_MODE = 12'h008;
    localparam logic [11:0] OFF_BOT_BASE = 12'h010;
    localparam logic [11:0] OFF_STRIDE_GRAB = 12'h014;
    localparam logic [11:0] OFF_DISP_CFG = 12'h018;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h040;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h044;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BASE_LSB = 2;
    localparam int STRIDE_LSB = 18;
    localparam int STRIDE_MSB = 31;
    localparam int OVF_BIT = 8;
    localparam int GRAB_MODE_BIT = 1;
    localparam int GRAB_CMD_BIT = 0;
    localparam int ENABLE_BIT = 31;
    localparam int THRESH_LSB = 24;
    localparam int THRESH_MSB = 30;
    localparam int HEIGHT_LSB = 12;
    localparam int HEIGHT_MSB = 21;
    localparam int WIDTH_LSB = 0;
    localparam int WIDTH_MSB = 9;
    localparam int SINGLE_FIELD_BIT = 6;

    // interrupt status / mask bit positions
    localparam int IRQ_OVF = 0;
    localparam int IRQ_GRAB_DONE = 1;
    localparam int IRQ_FIELD = 2;
    localparam int IRQ_BITS = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] BOT_BASE_RST = 32'h0fff_fffc;
    localparam logic [15:0] STRIDE_RST = 16'hfffc;
    localparam logic [6:0] THRESH_RST = 7'h0f;
    localparam logic [9:0] HEIGHT_RST = 10'h0f0;
    localparam logic [9:0] WIDTH_RST = 10'h3ff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GRAB_IDLE,
        GRAB_ARMED,
        GRAB_FIRST,
        GRAB_SECOND
    } grab_e;

    // what the line address generator needs for one field
    typedef struct packed {
        logic [31:0] base;
        logic [15:0] stride;
        logic [9:0] height;
    } line_cfg_s;

endpackage : vdma_pkg

// ===== verilog/line_addr_gen.sv
// display line address generator for the video write dma.
// assumes fieldStart and lineDone are one-cycle pulses on mclk and that
// lastPixelAddr is valid whenever lineDone is high.
`timescale 1ns/10ps
module line_addr_gen
    import vdma_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic fieldStart,
    input wire logic lineDone,
    input wire logic [31:0] lastPixelAddr,
    input wire line_cfg_s cfg,
    output logic [31:0] lineAddr,
    output logic [9:0] lineIndex,
    output logic fieldComplete
);

    typedef struct packed {
        logic [31:0] addr;
        logic [9:0] idx;
        logic done;
    } line_s;

    line_s st_reg;
    line_s st_next;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // field start wins over a line end in the same cycle: new field base
    always_comb begin
        st_next = st_reg;
        if (fieldStart) begin
            st_next.addr = cfg.base; // RULE18
            st_next.idx = 10'h000;
            st_next.done = (cfg.height == 10'h000);
        end else if (lineDone && !st_reg.done) begin
            st_next.addr = lastPixelAddr + {16'h0000, cfg.stride}; // RULE2
            st_next.idx = st_reg.idx + 10'h001;
            st_next.done = ((st_reg.idx + 10'h001) == cfg.height);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lineAddr = st_reg.addr;
    assign lineIndex = st_reg.idx;
    assign fieldComplete = st_reg.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_line_step: assert property ( // RULE2
        (lineDone && !fieldStart && !st_reg.done) |=>
            lineAddr == $past(lastPixelAddr) + {16'h0000, $past(cfg.stride)})
        else $error("line address is not last pixel plus stride");

    chk_field_restart: assert property ( // RULE18
        fieldStart |=> (lineAddr == $past(cfg.base)) && (lineIndex == 10'h000))
        else $error("field start did not reload the field base");

endmodule : line_addr_gen

// ===== verilog/video_display_dma_control.sv
// control and status registers of the video write dma path, with grab
// sequencing, burst request and line addressing.
// assumes an apb master on mclk, a vertical sync pin from the video source
// and fifo level / overflow / line-done signals from logic on mclk.
//
// Function
// RULE1: bottom field base held in bits 31:2, low two bits read zero.
// RULE2: next line address is last pixel address plus byte stride.
// RULE3: driver programs stride zero or line size for contiguous lines.
// RULE4: stride resets to 0xfffc; bits 17:16 read zero.
// RULE5: fifo overflow sets flag bit 8; flag resets to zero.
// RULE6: writing one clears overflow flag; a simultaneous overflow keeps it set.
// RULE7: grab mode bit 1 selects single grab; zero means continuous display.
// RULE8: grab command with grab mode set captures next two fields.
// RULE9: after second grabbed field, hardware clears grab command and stops.
// RULE10: host access and completion clear together leave grab command zero.
// RULE11: display enable bit 31 low suppresses all video write transfers.
// RULE12: request burst once fifo holds threshold doublewords; resets to 0x0f.
// RULE13: bit 24 picks bridge request behaviour; one is default bridge.
// RULE14: shared bit 24 makes threshold odd or even with bridge type.
// RULE15: window height bits 21:12 gives lines per field, resets 0x0f0.
// RULE16: window width bits 9:0 in pixels, resets 0x3ff.
// RULE17: display mode bit one is single field, zero emulated interlaced.
// RULE18: vertical sync rising edge marks fields for grab and line restart.
`timescale 1ns/10ps
module video_display_dma_control
    import vdma_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vsync,
    input wire logic fifoOverflow,
    input wire logic [6:0] fifoLevel,
    input wire logic lineDone,
    input wire logic [31:0] lastPixelAddr,
    input wire logic [31:0] topFieldBase,
    output logic burstReq,
    output logic transferActive,
    output logic [31:0] lineAddr,
    output logic [9:0] lineIndex,
    output logic fieldComplete,
    output logic fieldIsBottom,
    output logic singleFieldMode,
    output logic [9:0] windowWidth,
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [29:0] botBase;
        logic [13:0] stride;
        logic ovf;
        logic grabMode;
        logic grabCmd;
        logic enable;
        logic [6:0] thresh;
        logic [9:0] height;
        logic [9:0] width;
        logic singleField;
        logic [IRQ_BITS-1:0] irqStat;
        logic [IRQ_BITS-1:0] irqMask;
        logic ack;
        logic [31:0] rdata;
        logic vsMeta;
        logic vsSync;
        logic vsPrev;
        grab_e grab;
        logic req;
        logic parity;
    } ctl_s;

    ctl_s st_reg;
    ctl_s st_next;

    // address match, used for both read and write decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, OFF_DISP_MODE) || hit(a, OFF_BOT_BASE) ||
            hit(a, OFF_STRIDE_GRAB) || hit(a, OFF_DISP_CFG) ||
            hit(a, OFF_IRQ_STATUS) || hit(a, OFF_IRQ_MASK);
    endfunction : mapped

    // ------------------------------------------------------------
    // bus phase decode
    // ------------------------------------------------------------
    logic access;
    logic wrEn;
    logic vsEdge;
    logic grabDone;
    logic bridgeStd;
    logic [31:0] readWord;
    logic [IRQ_BITS-1:0] irqEvent;
    line_cfg_s lineCfg;

    // one wait state: ack rises after the first access cycle, so read data
    // can come from a flop without a combinational path from paddr
    assign access = psel && penable;
    assign wrEn = access && st_reg.ack && pwrite;
    assign pready = st_reg.ack;
    assign pslverr = st_reg.ack && !mapped(paddr);
    assign prdata = st_reg.rdata;

    // edge seen only after the two-stage synchroniser
    assign vsEdge = st_reg.vsSync && !st_reg.vsPrev; // RULE18
    assign grabDone = (st_reg.grab == GRAB_SECOND) && vsEdge; // RULE9

    // shared bit: threshold lsb doubles as bridge type
    assign bridgeStd = st_reg.thresh[0]; // RULE13 RULE14

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        readWord = 32'h0000_0000;
        if (hit(paddr, OFF_DISP_MODE)) begin
            readWord[SINGLE_FIELD_BIT] = st_reg.singleField; // RULE17
        end else if (hit(paddr, OFF_BOT_BASE)) begin
            readWord[31:BASE_LSB] = st_reg.botBase; // RULE1
        end else if (hit(paddr, OFF_STRIDE_GRAB)) begin
            readWord[STRIDE_MSB:STRIDE_LSB] = st_reg.stride; // RULE4
            readWord[OVF_BIT] = st_reg.ovf;
            readWord[GRAB_MODE_BIT] = st_reg.grabMode;
            readWord[GRAB_CMD_BIT] = st_reg.grabCmd;
        end else if (hit(paddr, OFF_DISP_CFG)) begin
            readWord[ENABLE_BIT] = st_reg.enable;
            readWord[THRESH_MSB:THRESH_LSB] = st_reg.thresh;
            readWord[HEIGHT_MSB:HEIGHT_LSB] = st_reg.height;
            readWord[WIDTH_MSB:WIDTH_LSB] = st_reg.width;
        end else if (hit(paddr, OFF_IRQ_STATUS)) begin
            readWord[IRQ_BITS-1:0] = st_reg.irqStat;
        end else if (hit(paddr, OFF_IRQ_MASK)) begin
            readWord[IRQ_BITS-1:0] = st_reg.irqMask;
        end
    end

    // ------------------------------------------------------------
    // transfer gating
    // ------------------------------------------------------------
    // in grab mode only the two captured fields may move data
    assign transferActive = st_reg.enable && !fieldComplete && // RULE11
        (!st_reg.grabMode || (st_reg.grab == GRAB_FIRST) ||
        (st_reg.grab == GRAB_SECOND)); // RULE7
    assign burstReq = st_reg.req;

    assign irqEvent[IRQ_OVF] = fifoOverflow;
    assign irqEvent[IRQ_GRAB_DONE] = grabDone;
    assign irqEvent[IRQ_FIELD] = vsEdge;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // apb handshake and read capture
        st_next.ack = access && !st_reg.ack;
        if (access && !st_reg.ack) begin
            st_next.rdata = pwrite ? 32'h0000_0000 : readWord;
        end

        // vertical sync synchroniser
        st_next.vsMeta = vsync;
        st_next.vsSync = st_reg.vsMeta;
        st_next.vsPrev = st_reg.vsSync;
        if (vsEdge) begin
            st_next.parity = !st_reg.parity;
        end

        // plain register writes
        if (wrEn && hit(paddr, OFF_DISP_MODE)) begin
            st_next.singleField = pwdata[SINGLE_FIELD_BIT]; // RULE17
        end
        if (wrEn && hit(paddr, OFF_BOT_BASE)) begin
            st_next.botBase = pwdata[31:BASE_LSB]; // RULE1
        end
        if (wrEn && hit(paddr, OFF_STRIDE_GRAB)) begin
            st_next.stride = pwdata[STRIDE_MSB:STRIDE_LSB]; // RULE4
            st_next.grabMode = pwdata[GRAB_MODE_BIT]; // RULE7
        end
        if (wrEn && hit(paddr, OFF_DISP_CFG)) begin
            st_next.enable = pwdata[ENABLE_BIT]; // RULE11
            st_next.thresh = pwdata[THRESH_MSB:THRESH_LSB]; // RULE12 RULE14
            st_next.height = pwdata[HEIGHT_MSB:HEIGHT_LSB]; // RULE15
            st_next.width = pwdata[WIDTH_MSB:WIDTH_LSB]; // RULE16
        end
        if (wrEn && hit(paddr, OFF_IRQ_MASK)) begin
            st_next.irqMask = pwdata[IRQ_BITS-1:0];
        end

        // overflow flag: write-one clears, a new overflow wins
        if (wrEn && hit(paddr, OFF_STRIDE_GRAB) && pwdata[OVF_BIT]) begin
            st_next.ovf = 1'b0; // RULE6
        end
        if (fifoOverflow) begin
            st_next.ovf = 1'b1; // RULE5 RULE6
        end

        // sticky interrupt status, set beats write-one clear
        if (wrEn && hit(paddr, OFF_IRQ_STATUS)) begin
            st_next.irqStat = st_reg.irqStat & ~pwdata[IRQ_BITS-1:0];
        end
        st_next.irqStat = st_next.irqStat | irqEvent;

        // grab command: host may only set it; completion clear wins
        if (wrEn && hit(paddr, OFF_STRIDE_GRAB) && pwdata[GRAB_CMD_BIT] &&
            pwdata[GRAB_MODE_BIT]) begin
            st_next.grabCmd = 1'b1; // RULE8
        end
        if (grabDone) begin
            st_next.grabCmd = 1'b0; // RULE9 RULE10
        end

        // grab sequencer, stepped by field boundaries
        unique case (st_reg.grab)
            GRAB_IDLE: begin
                if (st_next.grabCmd && st_next.grabMode) begin
                    st_next.grab = GRAB_ARMED;
                end
            end
            GRAB_ARMED: begin
                if (vsEdge) begin
                    st_next.grab = GRAB_FIRST; // RULE8
                end
            end
            GRAB_FIRST: begin
                if (vsEdge) begin
                    st_next.grab = GRAB_SECOND;
                end
            end
            GRAB_SECOND: begin
                if (vsEdge) begin
                    st_next.grab = GRAB_IDLE; // RULE9
                end
            end
        endcase
        if (!st_reg.grabMode) begin
            st_next.grab = GRAB_IDLE; // RULE7
        end

        // burst request with bridge-dependent release
        if (!transferActive) begin
            st_next.req = 1'b0; // RULE11
        end else if (!st_reg.req) begin
            st_next.req = (fifoLevel >= st_reg.thresh); // RULE12
        end else if (bridgeStd) begin
            st_next.req = (fifoLevel >= st_reg.thresh); // RULE13
        end else begin
            st_next.req = (fifoLevel != 7'h00); // RULE13
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.botBase <= BOT_BASE_RST[31:BASE_LSB]; // RULE1
            st_reg.stride <= STRIDE_RST[15:2]; // RULE4
            st_reg.thresh <= THRESH_RST; // RULE12 RULE13
            st_reg.height <= HEIGHT_RST; // RULE15
            st_reg.width <= WIDTH_RST; // RULE16
            st_reg.grab <= GRAB_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // line addressing
    // ------------------------------------------------------------
    // single-field mode writes every field at the bottom base
    always_comb begin
        lineCfg.base = (st_reg.singleField || !st_reg.parity) ?
            {st_reg.botBase, 2'b00} : topFieldBase;
        lineCfg.stride = {st_reg.stride, 2'b00}; // RULE4
        lineCfg.height = st_reg.height; // RULE15
    end

    line_addr_gen lineGen (
        .mclk(mclk),
        .resetn(resetn),
        .fieldStart(vsEdge),
        .lineDone(lineDone),
        .lastPixelAddr(lastPixelAddr),
        .cfg(lineCfg),
        .lineAddr(lineAddr),
        .lineIndex(lineIndex),
        .fieldComplete(fieldComplete)
    );

    assign fieldIsBottom = st_reg.singleField || !st_reg.parity; // RULE17
    assign singleFieldMode = st_reg.singleField;
    assign windowWidth = st_reg.width;
    assign irq = |(st_reg.irqStat & st_reg.irqMask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence grabArmedEdge;
        (st_reg.grab == GRAB_ARMED) && vsEdge;
    endsequence

    sequence grabLastEdge;
        (st_reg.grab == GRAB_SECOND) && vsEdge;
    endsequence

    chk_base_align: assert property ( // RULE1
        (pready && !pwrite && hit(paddr, OFF_BOT_BASE)) |-> prdata[1:0] == 2'b00)
        else $error("bottom base low bits not zero");

    chk_stride_zero: assert property ( // RULE4
        (pready && !pwrite && hit(paddr, OFF_STRIDE_GRAB)) |-> prdata[17:9] == 9'h000)
        else $error("stride low bits or reserved bits not zero");

    chk_ovf_set: assert property ( // RULE5
        fifoOverflow |=> st_reg.ovf && st_reg.irqStat[IRQ_OVF])
        else $error("overflow did not set the flag");

    chk_grab_start: assert property ( // RULE8
        grabArmedEdge |=> (st_reg.grab == GRAB_FIRST) || !$past(st_reg.grabMode))
        else $error("grab did not start on sync edge");

    chk_grab_done: assert property ( // RULE9
        grabLastEdge |=> !st_reg.grabCmd ##0 !transferActive || !st_reg.grabMode)
        else $error("grab command not cleared after second field");

    chk_grab_clash: assert property ( // RULE10
        (grabLastEdge and wrEn && hit(paddr, OFF_STRIDE_GRAB) && pwdata[0])
        |=> !st_reg.grabCmd)
        else $error("concurrent grab access did not end zero");

    chk_mode_exit: assert property ( // RULE7
        !st_reg.grabMode |=> st_reg.grab == GRAB_IDLE)
        else $error("grab sequencer active outside grab mode");

    chk_enable_off: assert property ( // RULE11
        !st_reg.enable |=> !burstReq)
        else $error("burst request while display disabled");

    chk_burst_rise: assert property ( // RULE12
        (transferActive && !burstReq && fifoLevel >= st_reg.thresh) |=> burstReq)
        else $error("burst not requested at threshold");

    chk_bridge_hold: assert property ( // RULE13
        (transferActive && burstReq && !bridgeStd && fifoLevel != 7'h00)
        |=> burstReq)
        else $error("alternate bridge released request early");

endmodule : video_display_dma_control

// ===== bench/host_bus_model.sv
// far-side model: video fills the fifo, host bus bursts drain it.
// assumes burstReq is a level from the dma block on mclk.
`timescale 1ns/10ps
module host_bus_model
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic burstReq,
    input wire logic fillOn,
    input wire logic slowGrant,
    output logic [6:0] fifoLevel
);
    logic phase;

    // -----------------------------------------------
    // fifo level
    // -----------------------------------------------
    // slow grant drains only every other cycle, like a busy bridge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fifoLevel <= 7'h00;
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
            if (burstReq && fifoLevel != 7'h00 && (!slowGrant || phase)) begin
                fifoLevel <= fifoLevel - 7'h01;
            end else if (fillOn && !burstReq && fifoLevel != 7'h7f) begin
                fifoLevel <= fifoLevel + 7'h01;
            end
        end
    end
endmodule : host_bus_model

// ===== bench/testbench.sv
// self-checking bench for the video write dma control block.
// assumes apb register access and the far-side fifo model.
`timescale 1ns/10ps
module testbench;
    import vdma_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, lineAddr, lastPixelAddr = 32'h0;
    logic [31:0] topFieldBase = 32'h0, seed = 32'd67886, base, r;
    logic pready, pslverr, burstReq, transferActive, fieldComplete, e;
    logic fieldIsBottom, singleFieldMode, irq, vsync = 1'b0;
    logic fifoOverflow = 1'b0, lineDone = 1'b0, fillOn = 1'b0, slowGrant = 1'b0;
    logic [6:0] fifoLevel;
    logic [9:0] lineIndex, windowWidth;
    int bad_count = 0;
    int n_checks = 0;

    always #5 mclk = ~mclk;

    video_display_dma_control u_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vsync(vsync),
        .fifoOverflow(fifoOverflow), .fifoLevel(fifoLevel), .lineDone(lineDone),
        .lastPixelAddr(lastPixelAddr), .topFieldBase(topFieldBase),
        .burstReq(burstReq), .transferActive(transferActive), .lineAddr(lineAddr),
        .lineIndex(lineIndex), .fieldComplete(fieldComplete),
        .fieldIsBottom(fieldIsBottom), .singleFieldMode(singleFieldMode),
        .windowWidth(windowWidth), .irq(irq));
    host_bus_model u_far (.mclk(mclk), .resetn(resetn), .burstReq(burstReq),
        .fillOn(fillOn), .slowGrant(slowGrant), .fifoLevel(fifoLevel));

    // -----------------------------------------------
    // helpers
    // -----------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; the answer is taken at the pready edge only
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            bad_count++;
            print_verdict();
        end
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rdchk

    // vsync held 3 cycles, then time for sync flops and reload
    task automatic vpulse();
        vsync <= 1'b1;
        repeat (3) @(posedge mclk);
        vsync <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : vpulse

    // bounded wait for a burst request level, sampled at settled time
    task automatic waitBurst(input logic lvl);
        int i;
        for (i = 0; i < 600 && burstReq !== lvl; i++) begin
            @(negedge mclk);
        end
        if (i >= 600) begin
            bad_count++;
            print_verdict();
        end
    endtask : waitBurst

    initial begin
        #1000000;
        bad_count++;
        print_verdict();
    end

    // -----------------------------------------------
    // main sequence
    // -----------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        topFieldBase <= lfsr(seed);
        rdchk(OFF_BOT_BASE, BOT_BASE_RST);
        rdchk(OFF_STRIDE_GRAB, {STRIDE_RST, 16'h0000});
        rdchk(OFF_DISP_CFG, 32'h0f0f_03ff);
        rdchk(OFF_DISP_MODE, 32'h0);
        chk({22'h0, windowWidth}, {22'h0, WIDTH_RST});
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            apb(1'b1, OFF_BOT_BASE, seed);
            rdchk(OFF_BOT_BASE, seed & 32'hffff_fffc);
            apb(1'b1, OFF_DISP_CFG, seed & 32'h7fff_ffff);
            rdchk(OFF_DISP_CFG, seed & 32'h7f3f_f3ff);
            apb(1'b1, OFF_STRIDE_GRAB, seed & 32'hffff_fefc);
            rdchk(OFF_STRIDE_GRAB, seed & 32'hfffc_0000);
        end
        // unmapped place: error answer, reads zero
        apb(1'b1, 12'h0fc, seed);
        chk({31'h0, e}, 32'h1);
        rdchk(12'h0fc, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, OFF_STRIDE_GRAB, 32'h0140_0000);
        // overflow set, interrupt, clear, and set winning over clear
        apb(1'b1, OFF_IRQ_MASK, 32'h1);
        fifoOverflow <= 1'b1;
        @(posedge mclk);
        fifoOverflow <= 1'b0;
        rdchk(OFF_STRIDE_GRAB, 32'h0140_0100);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFF_STRIDE_GRAB, 32'h0140_0100);
        rdchk(OFF_STRIDE_GRAB, 32'h0140_0000);
        fifoOverflow <= 1'b1;
        apb(1'b1, OFF_STRIDE_GRAB, 32'h0140_0100);
        fifoOverflow <= 1'b0;
        rdchk(OFF_STRIDE_GRAB, 32'h0140_0100);
        apb(1'b1, OFF_STRIDE_GRAB, 32'h0140_0100);
        rdchk(OFF_IRQ_STATUS, 32'h1);
        apb(1'b1, OFF_IRQ_STATUS, 32'h1);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
        // line addressing in single field mode
        apb(1'b1, OFF_DISP_CFG, 32'h850f_03ff);
        apb(1'b1, OFF_DISP_MODE, 32'h40);
        @(negedge mclk);
        chk({31'h0, singleFieldMode}, 32'h1);
        seed = lfsr(seed);
        base = seed & 32'hffff_fffc;
        apb(1'b1, OFF_BOT_BASE, seed);
        vpulse();
        chk(lineAddr, base);
        chk({31'h0, fieldIsBottom}, 32'h1);
        seed = lfsr(seed);
        lastPixelAddr <= seed;
        lineDone <= 1'b1;
        @(posedge mclk);
        lineDone <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk(lineAddr, seed + 32'h140);
        chk({22'h0, lineIndex}, 32'h1);
        chk({31'h0, fieldComplete}, 32'h0);
        // burst threshold, default bridge then the other bridge type
        fillOn <= 1'b1;
        waitBurst(1'b1);
        chk({31'h0, fifoLevel >= 7'h05}, 32'h1);
        waitBurst(1'b0);
        chk({31'h0, fifoLevel < 7'h05}, 32'h1);
        fillOn <= 1'b0;
        slowGrant <= 1'b1;
        apb(1'b1, OFF_DISP_CFG, 32'h860f_03ff);
        fillOn <= 1'b1;
        waitBurst(1'b1);
        chk({31'h0, fifoLevel >= 7'h06}, 32'h1);
        waitBurst(1'b0);
        chk({25'h0, fifoLevel}, 32'h0);
        apb(1'b1, OFF_DISP_CFG, 32'h060f_03ff);
        repeat (200) @(posedge mclk);
        chk({30'h0, burstReq, transferActive}, 32'h0);
        // frame grab over three field boundaries
        fillOn <= 1'b0;
        apb(1'b1, OFF_DISP_CFG, 32'h850f_03ff);
        apb(1'b1, OFF_STRIDE_GRAB, 32'h0140_0003);
        vpulse();
        vpulse();
        rdchk(OFF_STRIDE_GRAB, 32'h0140_0003);
        vpulse();
        rdchk(OFF_STRIDE_GRAB, 32'h0140_0002);
        chk({31'h0, transferActive}, 32'h0);
        rdchk(OFF_IRQ_STATUS, 32'h6);
        apb(1'b1, OFF_IRQ_MASK, 32'h2);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFF_IRQ_STATUS, 32'h6);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFF_STRIDE_GRAB, 32'h0140_0000);
        @(negedge mclk);
        chk({31'h0, transferActive}, 32'h1);
        print_verdict();
    end
endmodule : testbench
